/* File: src/swlt_ct_point.sv */
// start point of forwarding for cut-through or store-and-forward
`timescale 1ns/1ps
module swlt_ct_point #(
    parameter int LEN_W = 11
) (
    input wire logic clk, // core clock
    input wire logic rst, // synchronous reset
    input wire logic store_fwd, // whole packet before forwarding
    input wire logic [1:0] thr, // cycles ahead of midpoint
    input wire logic slow_to_fast, // ingress slower than egress
    input wire logic [LEN_W-1:0] pkt_len, // packet length in cycles
    output logic [LEN_W-1:0] start_at // forwarding start cycle
);
    logic [LEN_W-1:0] start_r, start_nxt;
    logic [LEN_W-1:0] half;

    initial begin
        if (LEN_W < 3) begin
            $error("swlt_ct_point: LEN_W too small");
        end
    end

    // a slow source would underrun a fast sink, so wait until midpoint
    always_comb begin
        half = pkt_len >> 1;
        if (store_fwd) begin
            start_nxt = pkt_len;
        end else if (slow_to_fast) begin
            if (half > LEN_W'(thr)) begin
                start_nxt = half - LEN_W'(thr);
            end else begin
                start_nxt = '0;
            end
        end else begin
            start_nxt = '0;
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            start_r <= '0;
        end else begin
            start_r <= start_nxt;
        end
    end

    assign start_at = start_r;

    store_waits_a: assert property (@(posedge clk) disable iff (rst)
        store_fwd |=> start_at == $past(pkt_len))
        else $error("store-and-forward does not wait for whole packet");
    midpoint_ahead_a: assert property (@(posedge clk) disable iff (rst)
        !store_fwd && slow_to_fast && (pkt_len >> 1) > 8
        |=> start_at == ($past(pkt_len) >> 1) - $past(thr))
        else $error("cut-through threshold not applied to midpoint");
endmodule

/* File: src/swlt_pkg.sv */
// constants for the switch link tuning register bank
package swlt_pkg;
    // register offsets
    localparam logic [7:0] OFF_TEST0 = 8'h68;
    localparam logic [7:0] OFF_TEST1 = 8'h6C;
    localparam logic [7:0] OFF_TIMER = 8'h70;
    localparam logic [7:0] OFF_FWD = 8'h74;
    // reset values
    localparam logic [31:0] RST_TEST0 = 32'h0400_1060;
    localparam logic [31:0] RST_TEST1 = 32'h0400_0800;
    localparam logic [11:0] RST_REPLAY = 12'h000;
    localparam logic [13:0] RST_ACK = 14'h0000;
    localparam logic RST_VGA = 1'h1;
    localparam logic [1:0] RST_THR = 2'h1;
    // timer word fields
    localparam int REPLAY_LSB = 0;
    localparam int REPLAY_W = 12;
    localparam int REPLAY_EN_BIT = 12;
    localparam int ACK_LSB = 16;
    localparam int ACK_W = 14;
    localparam int ACK_EN_BIT = 30;
    localparam int VGA_BIT = 31;
    // forwarding policy word fields
    localparam int STORE_BIT = 0;
    localparam int THR_LSB = 1;
    localparam int ARB_BIT = 3;
    localparam int CRED_BIT = 4;
    localparam int XORD_BIT = 5;
    localparam int TORD_BIT = 6;
    // credit types released to the partner
    localparam int CRED_TYPES = 3;
    // credit release sequencer
    typedef enum logic [0:0] {
        UPD_IDLE = 1'b0,
        UPD_GAP = 1'b1
    } swlt_upd_t;
endpackage

/* File: src/swlt_regs.sv */
// switch link tuning register bank and the policies it steers
`timescale 1ns/1ps
//
// Contract
// - user replay value, 12 bits at 11:0, writable, resets to zero.
// - replay enable bit 12 selects the user replay value.
// - user ACK latency value, 14 bits at 29:16, resets to zero.
// - ACK latency enable bit 30 selects the user ACK value.
// - bit 31 is read-only VGA decode enable, resets to one.
// - bit 0 set means store-and-forward, clear means cut-through.
// - threshold 2:1 sets start point for slow-to-fast forwarding.
// - threshold 00 is midpoint, 01..11 start 1..3 cycles earlier.
// - arbitration bit 3 set keeps granted port while it requests.
// - arbitration bit clear moves only to ports with enough credit.
// - credit bit 4 set releases all credit types per update.
// - credit bit clear releases one credit type per update.
// - bit 5 enables ordering across different egress ports.
// - bit 6 enables ordering among completions of different tags.
// - management-bus or EEPROM writes may replace reset defaults.
// - two writable test words reset to 04001060h and 04000800h.
module swlt_regs #(
    parameter int PORTS = 4,
    parameter int LEN_W = 11
) (
    input wire logic CORE_CLK, // core clock, 10 MHz
    input wire logic RST, // synchronous reset, active high
    input wire logic CFG_WR, // configuration write strobe
    input wire logic CFG_RD, // configuration read strobe
    input wire logic [7:0] CFG_ADDR, // configuration byte offset
    input wire logic [3:0] CFG_BE, // configuration byte enables
    input wire logic [31:0] CFG_WDATA, // configuration write data
    output logic [31:0] CFG_RDATA, // configuration read data
    output logic CFG_RVALID, // read data valid pulse
    input wire logic SMB_WR, // management bus word write
    input wire logic [7:0] SMB_ADDR, // management bus offset
    input wire logic [31:0] SMB_WDATA, // management bus data
    output logic SMB_RDY, // management write accepted
    input wire logic EE_WR, // eeprom auto-load word write
    input wire logic [7:0] EE_ADDR, // eeprom load offset
    input wire logic [31:0] EE_WDATA, // eeprom load data
    output logic EE_RDY, // eeprom write accepted
    input wire logic [11:0] DEF_REPLAY, // built-in replay time-out
    input wire logic [13:0] DEF_ACK, // built-in ack latency
    output logic [11:0] REPLAY_LIMIT, // replay time-out in use
    output logic [13:0] ACK_LIMIT, // ack latency in use
    input wire logic [31:0] DEC_ADDR, // address to decode
    input wire logic DEC_IS_IO, // address is an io access
    output logic VGA_DECODE_EN, // vga range decode enabled
    output logic VGA_HIT, // address falls in vga range
    input wire logic SLOW_TO_FAST, // ingress slower than egress
    input wire logic [LEN_W-1:0] PKT_LEN, // packet length in cycles
    output logic STORE_FWD, // store-and-forward active
    output logic [LEN_W-1:0] FWD_START, // cycle to start forwarding
    input wire logic ARB_ADV, // arbitration point
    input wire logic [PORTS-1:0] ARB_REQ, // port requests
    input wire logic [PORTS-1:0] ARB_CRED_OK, // enough credit per port
    output logic [PORTS-1:0] ARB_GNT, // one-hot grant
    input wire logic [2:0] CRED_PEND, // credit types awaiting release
    output logic UPD_VALID, // credit update pulse
    output logic [2:0] UPD_TYPES, // types carried by the update
    output logic XPORT_ORDER, // ordering across egress ports
    output logic TAG_ORDER, // ordering across completion tags
    output logic [31:0] PHY_TEST_WORD_0, // test-only control word 0
    output logic [31:0] PHY_TEST_WORD_1 // test-only control word 1
);
    localparam int CT = swlt_pkg::CRED_TYPES;

    initial begin
        if (CT != 3) begin
            $error("swlt_regs: credit type count must be 3");
        end
    end

    // merge write data under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
            input logic [31:0] new_w, input logic [3:0] be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // register state
    logic [11:0] rep_val_r, rep_val_nxt;
    logic rep_en_r, rep_en_nxt;
    logic [13:0] ack_val_r, ack_val_nxt;
    logic ack_en_r, ack_en_nxt;
    logic [6:0] pol_r, pol_nxt;
    logic [31:0] test0_r, test0_nxt, test1_r, test1_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [11:0] rep_lim_r, rep_lim_nxt;
    logic [13:0] ack_lim_r, ack_lim_nxt;
    logic vga_hit_r, vga_hit_nxt;
    // write port selection
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_be;
    logic [31:0] w_timer, w_pol, m_timer, m_pol;

    // config space wins, then management bus, then eeprom load
    assign SMB_RDY = !CFG_WR;
    assign EE_RDY = !CFG_WR && !SMB_WR;

    always_comb begin
        wr_en = CFG_WR || SMB_WR || EE_WR;
        wr_addr = EE_ADDR;
        wr_data = EE_WDATA;
        wr_be = 4'hF;
        if (CFG_WR) begin
            wr_addr = CFG_ADDR;
            wr_data = CFG_WDATA;
            wr_be = CFG_BE;
        end else if (SMB_WR) begin
            wr_addr = SMB_ADDR;
            wr_data = SMB_WDATA;
        end
    end

    // read-back words; capability-disable and reserved bits read zero
    always_comb begin
        w_timer = 32'h0000_0000;
        w_timer[swlt_pkg::REPLAY_LSB +: swlt_pkg::REPLAY_W] = rep_val_r;
        w_timer[swlt_pkg::REPLAY_EN_BIT] = rep_en_r;
        w_timer[swlt_pkg::ACK_LSB +: swlt_pkg::ACK_W] = ack_val_r;
        w_timer[swlt_pkg::ACK_EN_BIT] = ack_en_r;
        w_timer[swlt_pkg::VGA_BIT] = swlt_pkg::RST_VGA;
        w_pol = {25'h000_0000, pol_r};
    end

    // next values of the register file
    always_comb begin
        m_timer = be_merge(w_timer, wr_data, wr_be);
        m_pol = be_merge(w_pol, wr_data, wr_be);
        rep_val_nxt = rep_val_r;
        rep_en_nxt = rep_en_r;
        ack_val_nxt = ack_val_r;
        ack_en_nxt = ack_en_r;
        pol_nxt = pol_r;
        test0_nxt = test0_r;
        test1_nxt = test1_r;
        if (wr_en) begin
            case (wr_addr)
                swlt_pkg::OFF_TEST0: begin
                    test0_nxt = be_merge(test0_r, wr_data, wr_be);
                end
                swlt_pkg::OFF_TEST1: begin
                    test1_nxt = be_merge(test1_r, wr_data, wr_be);
                end
                swlt_pkg::OFF_TIMER: begin
                    // bit 31 is never taken from the write
                    rep_val_nxt = m_timer[swlt_pkg::REPLAY_LSB +:
                        swlt_pkg::REPLAY_W];
                    rep_en_nxt = m_timer[swlt_pkg::REPLAY_EN_BIT];
                    ack_val_nxt = m_timer[swlt_pkg::ACK_LSB +:
                        swlt_pkg::ACK_W];
                    ack_en_nxt = m_timer[swlt_pkg::ACK_EN_BIT];
                end
                swlt_pkg::OFF_FWD: begin
                    pol_nxt = m_pol[6:0];
                end
                default: begin
                    pol_nxt = pol_r;
                end
            endcase
        end
    end

    // read port: unmapped offsets answer zero one cycle later
    always_comb begin
        rvalid_nxt = CFG_RD;
        rdata_nxt = 32'h0000_0000;
        if (CFG_RD) begin
            case (CFG_ADDR)
                swlt_pkg::OFF_TEST0: rdata_nxt = test0_r;
                swlt_pkg::OFF_TEST1: rdata_nxt = test1_r;
                swlt_pkg::OFF_TIMER: rdata_nxt = w_timer;
                swlt_pkg::OFF_FWD: rdata_nxt = w_pol;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // timer selection and vga range decode
    always_comb begin
        rep_lim_nxt = rep_en_r ? rep_val_r : DEF_REPLAY;
        ack_lim_nxt = ack_en_r ? ack_val_r : DEF_ACK;
        if (DEC_IS_IO) begin
            vga_hit_nxt = (DEC_ADDR[15:0] >= 16'h03B0
                && DEC_ADDR[15:0] <= 16'h03BB)
                || (DEC_ADDR[15:0] >= 16'h03C0
                && DEC_ADDR[15:0] <= 16'h03DF);
        end else begin
            vga_hit_nxt = DEC_ADDR >= 32'h000A_0000
                && DEC_ADDR <= 32'h000B_FFFF;
        end
        vga_hit_nxt = vga_hit_nxt && swlt_pkg::RST_VGA;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rep_val_r <= swlt_pkg::RST_REPLAY;
            rep_en_r <= 1'b0;
            ack_val_r <= swlt_pkg::RST_ACK;
            ack_en_r <= 1'b0;
            pol_r <= {4'h0, swlt_pkg::RST_THR, 1'b0};
            test0_r <= swlt_pkg::RST_TEST0;
            test1_r <= swlt_pkg::RST_TEST1;
            rdata_r <= 32'h0000_0000;
            rvalid_r <= 1'b0;
            rep_lim_r <= 12'h000;
            ack_lim_r <= 14'h0000;
            vga_hit_r <= 1'b0;
        end else begin
            rep_val_r <= rep_val_nxt;
            rep_en_r <= rep_en_nxt;
            ack_val_r <= ack_val_nxt;
            ack_en_r <= ack_en_nxt;
            pol_r <= pol_nxt;
            test0_r <= test0_nxt;
            test1_r <= test1_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            rep_lim_r <= rep_lim_nxt;
            ack_lim_r <= ack_lim_nxt;
            vga_hit_r <= vga_hit_nxt;
        end
    end

    // credit release sequencer; a gap cycle lets the pending mask settle
    swlt_pkg::swlt_upd_t upd_st_r, upd_st_nxt;
    logic [1:0] rot_r, rot_nxt;
    logic upd_v_r, upd_v_nxt;
    logic [2:0] upd_t_r, upd_t_nxt;

    always_comb begin
        logic [1:0] idx;
        logic found;
        idx = 2'h0;
        found = 1'b0;
        upd_st_nxt = upd_st_r;
        rot_nxt = rot_r;
        upd_v_nxt = 1'b0;
        upd_t_nxt = 3'h0;
        case (upd_st_r)
            swlt_pkg::UPD_IDLE: begin
                if (CRED_PEND != 3'h0) begin
                    upd_v_nxt = 1'b1;
                    upd_st_nxt = swlt_pkg::UPD_GAP;
                    if (pol_r[swlt_pkg::CRED_BIT]) begin
                        upd_t_nxt = CRED_PEND;
                    end else begin
                        // rotate so no type starves the others
                        for (int i = 0; i < CT; i++) begin
                            // int width so the wrap cannot overflow 2 bits
                            idx = 2'((int'(rot_r) + i) % CT);
                            if (!found && CRED_PEND[idx]) begin
                                found = 1'b1;
                                upd_t_nxt = 3'h0;
                                upd_t_nxt[idx] = 1'b1;
                                rot_nxt = (idx == 2'(CT - 1)) ?
                                    2'h0 : idx + 2'h1;
                            end
                        end
                    end
                end
            end
            swlt_pkg::UPD_GAP: begin
                upd_st_nxt = swlt_pkg::UPD_IDLE;
            end
            default: begin
                upd_st_nxt = swlt_pkg::UPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            upd_st_r <= swlt_pkg::UPD_IDLE;
            rot_r <= 2'h0;
            upd_v_r <= 1'b0;
            upd_t_r <= 3'h0;
        end else begin
            upd_st_r <= upd_st_nxt;
            rot_r <= rot_nxt;
            upd_v_r <= upd_v_nxt;
            upd_t_r <= upd_t_nxt;
        end
    end

    swlt_ct_point #(.LEN_W(LEN_W)) u_ct (
        .clk(CORE_CLK),
        .rst(RST),
        .store_fwd(pol_r[swlt_pkg::STORE_BIT]),
        .thr(pol_r[swlt_pkg::THR_LSB +: 2]),
        .slow_to_fast(SLOW_TO_FAST),
        .pkt_len(PKT_LEN),
        .start_at(FWD_START)
    );

    swlt_rr_arb #(.PORTS(PORTS)) u_arb (
        .clk(CORE_CLK),
        .rst(RST),
        .stick_mode(pol_r[swlt_pkg::ARB_BIT]),
        .adv(ARB_ADV),
        .req(ARB_REQ),
        .cred_ok(ARB_CRED_OK),
        .gnt(ARB_GNT)
    );

    // outputs
    assign CFG_RDATA = rdata_r;
    assign CFG_RVALID = rvalid_r;
    assign REPLAY_LIMIT = rep_lim_r;
    assign ACK_LIMIT = ack_lim_r;
    assign VGA_DECODE_EN = swlt_pkg::RST_VGA;
    assign VGA_HIT = vga_hit_r;
    assign STORE_FWD = pol_r[swlt_pkg::STORE_BIT];
    assign XPORT_ORDER = pol_r[swlt_pkg::XORD_BIT];
    assign TAG_ORDER = pol_r[swlt_pkg::TORD_BIT];
    assign UPD_VALID = upd_v_r;
    assign UPD_TYPES = upd_t_r;
    assign PHY_TEST_WORD_0 = test0_r;
    assign PHY_TEST_WORD_1 = test1_r;

    // the release edge still loads the reset limits, so it is left out
    replay_user_a: assert property (@(posedge CORE_CLK)
        disable iff (RST) !RST && rep_en_r
        |=> REPLAY_LIMIT == $past(rep_val_r))
        else $error("user replay value not in use");
    replay_builtin_a: assert property (@(posedge CORE_CLK)
        disable iff (RST) !RST && !rep_en_r
        |=> REPLAY_LIMIT == $past(DEF_REPLAY))
        else $error("built-in replay value not in use");
    ack_select_a: assert property (@(posedge CORE_CLK)
        disable iff (RST) !RST
        |=> ACK_LIMIT == ($past(ack_en_r) ? $past(ack_val_r)
        : $past(DEF_ACK)))
        else $error("ack latency selection wrong");
    vga_ro_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        CFG_RD && CFG_ADDR == swlt_pkg::OFF_TIMER
        |=> CFG_RVALID && CFG_RDATA[31])
        else $error("vga decode enable not reading one");
    test_reset_a: assert property (@(posedge CORE_CLK)
        RST |=> PHY_TEST_WORD_0 == 32'h0400_1060
        && PHY_TEST_WORD_1 == 32'h0400_0800)
        else $error("test word reset value wrong");
    thr_reset_a: assert property (@(posedge CORE_CLK)
        RST |=> pol_r == 7'h02)
        else $error("forwarding policy reset value wrong");
    // the mode that chose the types is the one of the previous edge
    single_type_a: assert property (@(posedge CORE_CLK)
        disable iff (RST) $rose(UPD_VALID)
        && !$past(pol_r[swlt_pkg::CRED_BIT]) |-> $onehot(UPD_TYPES))
        else $error("type-oriented update carries several types");
    all_types_a: assert property (@(posedge CORE_CLK)
        disable iff (RST) upd_st_r == swlt_pkg::UPD_IDLE
        && CRED_PEND != 3'h0 && pol_r[swlt_pkg::CRED_BIT]
        |=> UPD_VALID && UPD_TYPES == $past(CRED_PEND))
        else $error("all-types update missing a type");
    smb_write_a: assert property (@(posedge CORE_CLK)
        disable iff (RST) SMB_WR && !CFG_WR && SMB_ADDR == swlt_pkg::OFF_FWD
        |=> STORE_FWD == $past(SMB_WDATA[0])
        && XPORT_ORDER == $past(SMB_WDATA[5]))
        else $error("management write did not replace policy");
endmodule

/* File: src/swlt_rr_arb.sv */
// round-robin port arbiter with sticky or credit-checked hand-over
`timescale 1ns/1ps
module swlt_rr_arb #(
    parameter int PORTS = 4
) (
    input wire logic clk, // core clock
    input wire logic rst, // synchronous reset
    input wire logic stick_mode, // stay on granted port while it requests
    input wire logic adv, // arbitration point
    input wire logic [PORTS-1:0] req, // port requests
    input wire logic [PORTS-1:0] cred_ok, // enough egress credit per port
    output logic [PORTS-1:0] gnt // one-hot grant
);
    localparam int PW = $clog2(PORTS);
    logic [PORTS-1:0] gnt_r, gnt_nxt;
    logic [PW-1:0] ptr_r, ptr_nxt;

    initial begin
        if (PORTS < 2 || (1 << PW) != PORTS) begin
            $error("swlt_rr_arb: PORTS must be a power of two >= 2");
        end
    end

    // search from the port after the last winner so nobody starves
    always_comb begin
        logic found;
        logic [PW-1:0] idx;
        found = 1'b0;
        idx = '0;
        gnt_nxt = gnt_r;
        ptr_nxt = ptr_r;
        if (adv) begin
            if (stick_mode && req[ptr_r]) begin
                gnt_nxt = '0;
                gnt_nxt[ptr_r] = 1'b1;
            end else begin
                gnt_nxt = '0;
                for (int i = 1; i <= PORTS; i++) begin
                    idx = PW'(ptr_r + PW'(i));
                    if (!found && req[idx] && cred_ok[idx]) begin
                        found = 1'b1;
                        ptr_nxt = idx;
                        gnt_nxt[idx] = 1'b1;
                    end
                end
            end
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            gnt_r <= '0;
            ptr_r <= '0;
        end else begin
            gnt_r <= gnt_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    assign gnt = gnt_r;

    stay_granted_a: assert property (@(posedge clk) disable iff (rst)
        adv && stick_mode && req[ptr_r] |=> gnt[$past(ptr_r)])
        else $error("sticky arbiter left a requesting port");
    credit_checked_a: assert property (@(posedge clk) disable iff (rst)
        adv && !stick_mode |=> (gnt & ~($past(req) & $past(cred_ok))) == '0)
        else $error("grant given to port without credit");
endmodule

/* File: tb/switch_link_tuning_regs_tb.sv */
// self-checking bench for the switch link tuning register bank
`timescale 1ns/1ps
module switch_link_tuning_regs_tb;
    logic clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic smb_wr = 1'b0, ee_wr = 1'b0, io = 1'b0, slow = 1'b0, adv = 1'b0;
    logic [7:0] addr = 8'h00, smb_addr = 8'h00, ee_addr = 8'h00;
    logic [3:0] be = 4'hF, req = 4'h0, cok = 4'h0, gnt;
    logic [31:0] wd = 32'h0, smb_wd = 32'h0, ee_wd = 32'h0, dec = 32'h0;
    logic [31:0] rdata, tw0, tw1;
    logic [11:0] def_rep = 12'h123, rep;
    logic [13:0] def_ack = 14'h0456, ack;
    logic [10:0] len = 11'h014, start;
    logic [2:0] pend = 3'h0, types;
    logic rvalid, smb_rdy, ee_rdy, vga_en, vga_hit, store, upd, xord, tord;
    int mismatches = 0, checks_done = 0;
    // 100 ns core clock
    always #50 clk = ~clk;
    swlt_regs dut_u (.CORE_CLK(clk), .RST(rst), .CFG_WR(cfg_wr),
        .CFG_RD(cfg_rd), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wd),
        .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .SMB_WR(smb_wr),
        .SMB_ADDR(smb_addr), .SMB_WDATA(smb_wd), .SMB_RDY(smb_rdy),
        .EE_WR(ee_wr), .EE_ADDR(ee_addr), .EE_WDATA(ee_wd), .EE_RDY(ee_rdy),
        .DEF_REPLAY(def_rep), .DEF_ACK(def_ack), .REPLAY_LIMIT(rep),
        .ACK_LIMIT(ack), .DEC_ADDR(dec), .DEC_IS_IO(io),
        .VGA_DECODE_EN(vga_en), .VGA_HIT(vga_hit), .SLOW_TO_FAST(slow),
        .PKT_LEN(len), .STORE_FWD(store), .FWD_START(start),
        .ARB_ADV(adv), .ARB_REQ(req), .ARB_CRED_OK(cok), .ARB_GNT(gnt),
        .CRED_PEND(pend), .UPD_VALID(upd), .UPD_TYPES(types),
        .XPORT_ORDER(xord), .TAG_ORDER(tord), .PHY_TEST_WORD_0(tw0),
        .PHY_TEST_WORD_1(tw1));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one word write; s picks config, management bus or eeprom source
    task automatic put(input int s, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        if (s == 0) begin
            cfg_wr <= 1'b1; addr <= a; wd <= d;
        end else if (s == 1) begin
            smb_wr <= 1'b1; smb_addr <= a; smb_wd <= d;
        end else begin
            ee_wr <= 1'b1; ee_addr <= a; ee_wd <= d;
        end
        @(posedge clk);
        cfg_wr <= 1'b0; smb_wr <= 1'b0; ee_wr <= 1'b0;
    endtask
    // read answer is registered on the taking edge and checked just after it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        cfg_rd <= 1'b1; addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1;
        chk({31'h0, rvalid}, 32'h1);
        chk(rdata, e);
    endtask
    // let a register change reach the registered policy outputs
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic arb(input logic [3:0] r, input logic [3:0] c);
        @(posedge clk);
        adv <= 1'b1; req <= r; cok <= c;
        @(posedge clk);
        adv <= 1'b0;
        #1;
    endtask
    // bounded wait for a credit update pulse
    task automatic wait_upd();
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (upd === 1'b1) break;
        end
        if (i == 8) begin
            mismatches++;
            $display("Error at %0t: no credit update", $time);
            end_of_test();
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        rd(8'h68, swlt_pkg::RST_TEST0);
        rd(8'h6C, swlt_pkg::RST_TEST1);
        rd(8'h70, 32'h8000_0000);
        rd(8'h74, 32'h0000_0002);
        rd(8'h00, 32'h0000_0000);
        chk({20'h0, rep}, {20'h0, def_rep});
        $display("reset test done");
        put(0, 8'h70, 32'h5555_1ABC);
        rd(8'h70, 32'hD555_1ABC);
        chk({2'h0, ack, 4'h0, rep},
            {2'h0, 14'h1555, 4'h0, 12'hABC});
        put(0, 8'h70, 32'h0000_0ABC);
        settle();
        chk({2'h0, ack, 4'h0, rep},
            {2'h0, def_ack, 4'h0, def_rep});
        $display("timer test done");
        slow <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            put(0, 8'h74, 32'(t * 2));
            settle();
            chk({21'h0, start}, 32'(10 - t));
        end
        // policy set over the management bus this time
        put(1, 8'h74, 32'h0000_0061);
        settle();
        chk({18'h0, store, xord, tord, start},
            {18'h0, 3'h7, 11'h014});
        slow <= 1'b0;
        put(0, 8'h74, 32'h0000_0002);
        settle();
        chk({18'h0, store, xord, tord, start}, 32'h0);
        io <= 1'b1; dec <= 32'h0000_03C0;
        settle();
        chk({30'h0, vga_en, vga_hit}, 32'h3);
        $display("forwarding test done");
        put(1, 8'h68, 32'hA5A5_0001);
        put(2, 8'h6C, 32'h5A5A_0002);
        rd(8'h68, 32'hA5A5_0001);
        rd(8'h6C, 32'h5A5A_0002);
        // management write in the same cycle as a config write is dropped
        @(posedge clk);
        cfg_wr <= 1'b1; addr <= 8'h6C; wd <= 32'h1111_1111;
        smb_wr <= 1'b1; smb_addr <= 8'h68; smb_wd <= 32'h2222_2222;
        #1;
        chk({31'h0, smb_rdy}, 32'h0);
        chk({31'h0, ee_rdy}, 32'h0);
        @(posedge clk);
        cfg_wr <= 1'b0; smb_wr <= 1'b0;
        settle();
        chk(tw0, 32'hA5A5_0001);
        chk(tw1, 32'h1111_1111);
        $display("load test done");
        arb(4'h6, 4'h4);
        chk({28'h0, gnt}, 32'h4);
        put(0, 8'h74, 32'h0000_000A);
        arb(4'h4, 4'h0);
        chk({28'h0, gnt}, 32'h4);
        put(0, 8'h74, 32'h0000_0002);
        arb(4'h4, 4'h0);
        chk({28'h0, gnt}, 32'h0);
        $display("arbiter test done");
        pend <= 3'h5;
        wait_upd();
        chk({29'h0, types}, 32'h1);
        // type 1 alone, twice: the second search must wrap past type 2
        pend <= 3'h2;
        wait_upd();
        chk({29'h0, types}, 32'h2);
        wait_upd();
        chk({29'h0, types}, 32'h2);
        pend <= 3'h0;
        put(0, 8'h74, 32'h0000_0012);
        pend <= 3'h7;
        wait_upd();
        chk({29'h0, types}, 32'h7);
        pend <= 3'h0;
        $display("credit test done");
        end_of_test();
    end
endmodule
